// File: rtl/grm_register_map.sv
`timescale 1ns/100ps
module grm_register_map #(
    parameter longint unsigned GAP_CYC = grm_pkg::SAMPLE_GAP_CYC,
    parameter longint unsigned MIN_CYC = grm_pkg::MINUTE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] cmd_code,
    input wire logic wr_stb,
    input wire logic [15:0] wr_data,
    input wire logic rd_stb,
    output logic [15:0] rd_data_r,
    output logic rd_valid_r,
    output logic cmd_refused_r,
    input wire logic meas_stb,
    input wire logic [15:0] cell_voltage_mv,
    input wire logic [15:0] cell_temp_dk,
    input wire logic [7:0] relative_charge_level,
    input wire logic tte_stb,
    input wire logic [15:0] tte_estimate,
    input wire logic amb_stb,
    input wire logic [15:0] ambient_temp_dk,
    input wire logic health_stb,
    input wire logic [15:0] health_pct,
    input wire logic uid_stb,
    input wire logic [31:0] uid_value,
    output logic seed_load_r,
    output logic [15:0] seed_voltage_r,
    output logic init_done_r
);
    import grm_pkg::*;

    logic [15:0] tte_r, term_r, empty_v_r, ei_ofs_r, hv_alm_r, lt_alm_r, ht_alm_r;
    logic [15:0] run_lo_r, tacc_lo_r, tacc_hi_r, cacc_lo_r, cacc_hi_r;
    logic [7:0] run_hi_r;
    logic [15:0] vmax_r, vmin_r, tmax_r, tmin_r, amb_r, health_r;
    logic [31:0] uid_r;
    logic [15:0] samp_r [NUM_SAMPLES];
    grm_init_e state_r;
    logic [39:0] gap_cnt_r;
    logic [1:0] samp_idx_r;
    logic [39:0] min_cnt_r;
    logic min_tick;

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    logic wr_hit, rd_hit, wr_ok, live, readable, writable, in_range;
    assign live = (cmd_code >= CMD_FIRST_LIVE) && (cmd_code < CMD_LIMIT);
    always_comb begin
        readable = 1'b0;
        writable = 1'b0;
        in_range = 1'b1;
        unique case (cmd_code)
            CMD_TTE, CMD_RCL, CMD_AMB, CMD_HEALTH, CMD_UID_LO, CMD_UID_HI: begin
                readable = 1'b1;
            end
            CMD_SEL: begin
                writable = 1'b1;
            end
            CMD_TERM: begin
                readable = 1'b1;
                writable = 1'b1;
                in_range = (wr_data >= TERM_MIN) && (wr_data <= TERM_MAX);
            end
            CMD_EMPTY_V, CMD_HV_ALM: begin
                readable = 1'b1;
                writable = 1'b1;
                in_range = (wr_data == ZERO_RST) ||
                           ((wr_data >= VOLT_MIN) && (wr_data <= VOLT_MAX));
            end
            CMD_EI_OFS: begin
                readable = 1'b1;
                writable = 1'b1;
                in_range = wr_data <= EI_OFS_MAX;
            end
            CMD_LT_ALM, CMD_HT_ALM: begin
                readable = 1'b1;
                writable = 1'b1;
                in_range = (wr_data == ZERO_RST) ||
                           ((wr_data >= TEMP_MIN) && (wr_data <= TEMP_MAX));
            end
            CMD_VMAX, CMD_VMIN: begin
                readable = 1'b1;
                writable = 1'b1;
                in_range = (wr_data >= VOLT_MIN) && (wr_data <= VOLT_MAX);
            end
            CMD_TMAX, CMD_TMIN: begin
                readable = 1'b1;
                writable = 1'b1;
                in_range = (wr_data >= TEMP_MIN) && (wr_data <= TEMP_MAX);
            end
            CMD_RUN_HI: begin
                readable = 1'b1;
                writable = 1'b1;
                in_range = wr_data[15:8] == 8'h00;
            end
            CMD_RUN_LO, CMD_TACC_LO, CMD_TACC_HI, CMD_CACC_LO, CMD_CACC_HI: begin
                readable = 1'b1;
                writable = 1'b1;
            end
            default: begin
                readable = 1'b0;
                writable = 1'b0;
            end
        endcase
    end
    assign rd_hit = rd_stb && live && readable;
    assign wr_ok = wr_stb && live && writable && in_range;
    assign wr_hit = wr_ok && (cmd_code != CMD_SEL);

    // Sample-select key decode; a bad key or a key before init is refused
    logic sel_key_ok;
    logic [1:0] sel_idx;
    assign sel_key_ok = (wr_data >= SEL_KEY_BASE) && (wr_data <= SEL_KEY_LAST);
    assign sel_idx = 2'(wr_data - SEL_KEY_BASE);
    logic sel_go;
    assign sel_go = wr_ok && (cmd_code == CMD_SEL) && sel_key_ok && init_done_r;

    ////////////////////////////////////////////////////////////////////////
    // Read answer one cycle after the strobe; low word at lower code
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data_r <= ZERO_RST;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_stb;
            rd_data_r <= ZERO_RST;
            if (rd_hit) begin
                unique case (cmd_code)
                    CMD_TTE: rd_data_r <= tte_r;
                    CMD_RCL: rd_data_r <= {8'h00, relative_charge_level};
                    CMD_TERM: rd_data_r <= term_r;
                    CMD_EMPTY_V: rd_data_r <= empty_v_r;
                    CMD_EI_OFS: rd_data_r <= ei_ofs_r;
                    CMD_HV_ALM: rd_data_r <= hv_alm_r;
                    CMD_LT_ALM: rd_data_r <= lt_alm_r;
                    CMD_HT_ALM: rd_data_r <= ht_alm_r;
                    CMD_RUN_LO: rd_data_r <= run_lo_r;
                    CMD_RUN_HI: rd_data_r <= {8'h00, run_hi_r};
                    CMD_TACC_LO: rd_data_r <= tacc_lo_r;
                    CMD_TACC_HI: rd_data_r <= tacc_hi_r;
                    CMD_CACC_LO: rd_data_r <= cacc_lo_r;
                    CMD_CACC_HI: rd_data_r <= cacc_hi_r;
                    CMD_VMAX: rd_data_r <= vmax_r;
                    CMD_VMIN: rd_data_r <= vmin_r;
                    CMD_TMAX: rd_data_r <= tmax_r;
                    CMD_TMIN: rd_data_r <= tmin_r;
                    CMD_AMB: rd_data_r <= amb_r;
                    CMD_HEALTH: rd_data_r <= health_r;
                    CMD_UID_LO: rd_data_r <= uid_r[15:0];
                    CMD_UID_HI: rd_data_r <= uid_r[31:16];
                    default: rd_data_r <= ZERO_RST;
                endcase
            end
        end
    end

    // Refusal pulse: prohibited codes, holes, wrong direction, bad data
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cmd_refused_r <= 1'b0;
        end else begin
            cmd_refused_r <= (rd_stb && !rd_hit) ||
                             (wr_stb && !(wr_hit || sel_go));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host-writable thresholds; only in-range data is stored
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            term_r <= TERM_RST;
            empty_v_r <= ZERO_RST;
            ei_ofs_r <= ZERO_RST;
            hv_alm_r <= ZERO_RST;
            lt_alm_r <= ZERO_RST;
            ht_alm_r <= ZERO_RST;
        end else if (wr_hit) begin
            if (cmd_code == CMD_TERM) term_r <= wr_data;
            if (cmd_code == CMD_EMPTY_V) empty_v_r <= wr_data;
            if (cmd_code == CMD_EI_OFS) ei_ofs_r <= wr_data;
            if (cmd_code == CMD_HV_ALM) hv_alm_r <= wr_data;
            if (cmd_code == CMD_LT_ALM) lt_alm_r <= wr_data;
            if (cmd_code == CMD_HT_ALM) ht_alm_r <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Minute tick for run time and accumulators
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            min_cnt_r <= '0;
        end else if (min_tick) begin
            min_cnt_r <= '0;
        end else begin
            min_cnt_r <= min_cnt_r + 40'h1;
        end
    end
    assign min_tick = min_cnt_r == 40'(MIN_CYC - 1);

    // Counters; a host write to a word wins over that minute's increment
    logic [23:0] run_nxt;
    logic [31:0] tacc_nxt, cacc_nxt;
    assign run_nxt = {run_hi_r, run_lo_r} + 24'h1;
    assign tacc_nxt = {tacc_hi_r, tacc_lo_r} + {16'h0000, cell_temp_dk / TEMP_ACC_DIV};
    assign cacc_nxt = {cacc_hi_r, cacc_lo_r} + {24'h000000, relative_charge_level};
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            run_lo_r <= ZERO_RST;
            run_hi_r <= 8'h00;
            tacc_lo_r <= ZERO_RST;
            tacc_hi_r <= ZERO_RST;
            cacc_lo_r <= ZERO_RST;
            cacc_hi_r <= ZERO_RST;
        end else begin
            if (min_tick && state_r == GRM_DONE) begin
                {run_hi_r, run_lo_r} <= run_nxt;
                {tacc_hi_r, tacc_lo_r} <= tacc_nxt;
                {cacc_hi_r, cacc_lo_r} <= cacc_nxt;
            end
            if (wr_hit) begin
                if (cmd_code == CMD_RUN_LO) run_lo_r <= wr_data;
                if (cmd_code == CMD_RUN_HI) run_hi_r <= wr_data[7:0];
                if (cmd_code == CMD_TACC_LO) tacc_lo_r <= wr_data;
                if (cmd_code == CMD_TACC_HI) tacc_hi_r <= wr_data;
                if (cmd_code == CMD_CACC_LO) cacc_lo_r <= wr_data;
                if (cmd_code == CMD_CACC_HI) cacc_hi_r <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // History of extremes; a host write wins over a same-cycle measurement
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vmax_r <= ZERO_RST;
            vmin_r <= VMIN_RST;
            tmax_r <= TMAX_RST;
            tmin_r <= TMIN_RST;
        end else begin
            if (meas_stb) begin
                if (cell_voltage_mv > vmax_r) vmax_r <= cell_voltage_mv;
                if (cell_voltage_mv < vmin_r) vmin_r <= cell_voltage_mv;
                if (cell_temp_dk > tmax_r) tmax_r <= cell_temp_dk;
                if (cell_temp_dk < tmin_r) tmin_r <= cell_temp_dk;
            end
            if (wr_hit) begin
                if (cmd_code == CMD_VMAX) vmax_r <= wr_data;
                if (cmd_code == CMD_VMIN) vmin_r <= wr_data;
                if (cmd_code == CMD_TMAX) tmax_r <= wr_data;
                if (cmd_code == CMD_TMIN) tmin_r <= wr_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-only values loaded by the calculation side
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tte_r <= TTE_RST;
            amb_r <= AMB_RST;
            health_r <= HEALTH_RST;
            uid_r <= '0;
        end else begin
            // Empty means zero percent, so the estimate is forced to zero there
            if (tte_stb) tte_r <= (relative_charge_level == 8'h00) ? ZERO_RST : tte_estimate;
            if (amb_stb) amb_r <= ambient_temp_dk;
            // Clamp keeps the health figure on its 0..100 scale
            if (health_stb) health_r <= (health_pct > HEALTH_MAX) ? HEALTH_MAX : health_pct;
            if (uid_stb) uid_r <= uid_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Initial sequence: wait a gap, take a sample, four times over
    logic samp_take;
    assign samp_take = (state_r != GRM_DONE) && (gap_cnt_r == 40'(GAP_CYC - 1));
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= GRM_WAIT;
            gap_cnt_r <= '0;
            samp_idx_r <= 2'b00;
        end else begin
            unique case (state_r)
                GRM_WAIT: begin
                    gap_cnt_r <= gap_cnt_r + 40'h1;
                    if (samp_take) begin
                        gap_cnt_r <= '0;
                        state_r <= GRM_SAMPLE;
                    end
                end
                GRM_SAMPLE: begin
                    gap_cnt_r <= gap_cnt_r + 40'h1;
                    if (samp_take) begin
                        gap_cnt_r <= '0;
                        samp_idx_r <= samp_idx_r + 2'b01;
                        if (samp_idx_r == 2'(NUM_SAMPLES - 2)) state_r <= GRM_DONE;
                    end
                end
                GRM_DONE: begin
                    gap_cnt_r <= '0;
                end
                default: state_r <= GRM_WAIT;
            endcase
        end
    end

    // Sample store: written only during init, then frozen until reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_SAMPLES; i++) samp_r[i] <= ZERO_RST;
        end else if (samp_take) begin
            samp_r[(state_r == GRM_WAIT) ? 2'b00 : samp_idx_r + 2'b01] <= cell_voltage_mv;
        end
    end

    // Seed pulse: first sample at end of init, else the host's pick
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            seed_load_r <= 1'b0;
            seed_voltage_r <= ZERO_RST;
            init_done_r <= 1'b0;
        end else begin
            init_done_r <= state_r == GRM_DONE;
            seed_load_r <= 1'b0;
            if (state_r == GRM_DONE && !init_done_r) begin
                seed_load_r <= 1'b1;
                seed_voltage_r <= samp_r[0];
            end else if (sel_go) begin
                seed_load_r <= 1'b1;
                seed_voltage_r <= samp_r[sel_idx];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_refuse_low: assert property (@(posedge clk) disable iff (!reset_n)
        (rd_stb || wr_stb) && (cmd_code < CMD_FIRST_LIVE || cmd_code >= CMD_LIMIT)
        |=> cmd_refused_r)
        else $error("prohibited code not refused");
    a_tte_read: assert property (@(posedge clk) disable iff (!reset_n)
        rd_stb && cmd_code == CMD_TTE |=> rd_valid_r && rd_data_r == $past(tte_r))
        else $error("time to empty read wrong");
    a_tte_empty: assert property (@(posedge clk) disable iff (!reset_n)
        tte_stb && relative_charge_level == 8'h00 |=> tte_r == ZERO_RST)
        else $error("time to empty not zero when empty");
    a_select_seed: assert property (@(posedge clk) disable iff (!reset_n)
        sel_go |=> seed_load_r && seed_voltage_r == samp_r[$past(sel_idx)])
        else $error("selected sample not seeded");
    a_sample_gap: assert property (@(posedge clk) disable iff (!reset_n)
        samp_take |=> !samp_take [*2])
        else $error("samples taken too close");
    a_first_seed: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == GRM_DONE && !init_done_r |=> seed_load_r && seed_voltage_r == samp_r[0])
        else $error("first sample not seeded");
    a_samples_held: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == GRM_DONE |=> $stable(samp_r[0]) && $stable(samp_r[1]) &&
        $stable(samp_r[2]) && $stable(samp_r[3]))
        else $error("sample changed after init");
    a_term_range: assert property (@(posedge clk) disable iff (!reset_n)
        wr_stb && cmd_code == CMD_TERM && wr_data > TERM_MAX |=> $stable(term_r) && cmd_refused_r)
        else $error("out of range rate accepted");
    a_health_cap: assert property (@(posedge clk) disable iff (!reset_n)
        health_stb |=> health_r <= HEALTH_MAX)
        else $error("health above full scale");
endmodule : grm_register_map

// File: rtl/grm_pkg.sv
package grm_pkg;
    // Clock, init-sequence and minute-tick timing
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned SAMPLE_GAP_MS = 10;
    localparam longint unsigned SAMPLE_GAP_CYC = longint'(SAMPLE_GAP_MS) * CLK_KHZ;
    localparam int unsigned MINUTE_MS = 60000;
    localparam longint unsigned MINUTE_CYC = longint'(MINUTE_MS) * CLK_KHZ;
    localparam int unsigned NUM_SAMPLES = 4;

    // Command codes
    localparam logic [7:0] CMD_TTE = 8'h03;
    localparam logic [7:0] CMD_SEL = 8'h04;
    localparam logic [7:0] CMD_RCL = 8'h0D;
    localparam logic [7:0] CMD_TERM = 8'h1C;
    localparam logic [7:0] CMD_EMPTY_V = 8'h1D;
    localparam logic [7:0] CMD_EI_OFS = 8'h1E;
    localparam logic [7:0] CMD_HV_ALM = 8'h1F;
    localparam logic [7:0] CMD_LT_ALM = 8'h20;
    localparam logic [7:0] CMD_HT_ALM = 8'h21;
    localparam logic [7:0] CMD_RUN_LO = 8'h24;
    localparam logic [7:0] CMD_RUN_HI = 8'h25;
    localparam logic [7:0] CMD_TACC_LO = 8'h26;
    localparam logic [7:0] CMD_TACC_HI = 8'h27;
    localparam logic [7:0] CMD_CACC_LO = 8'h28;
    localparam logic [7:0] CMD_CACC_HI = 8'h29;
    localparam logic [7:0] CMD_VMAX = 8'h2A;
    localparam logic [7:0] CMD_VMIN = 8'h2B;
    localparam logic [7:0] CMD_TMAX = 8'h2C;
    localparam logic [7:0] CMD_TMIN = 8'h2D;
    localparam logic [7:0] CMD_AMB = 8'h30;
    localparam logic [7:0] CMD_HEALTH = 8'h32;
    localparam logic [7:0] CMD_UID_LO = 8'h36;
    localparam logic [7:0] CMD_UID_HI = 8'h37;
    localparam logic [7:0] CMD_FIRST_LIVE = 8'h02;
    localparam logic [7:0] CMD_LIMIT = 8'h40;

    // Sample-select keys, first key picks the first sample
    localparam logic [15:0] SEL_KEY_BASE = 16'hAA55;
    localparam logic [15:0] SEL_KEY_LAST = 16'hAA58;

    // Reset values
    localparam logic [15:0] TTE_RST = 16'hFFFF;
    localparam logic [15:0] TERM_RST = 16'h0002;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    localparam logic [15:0] VMIN_RST = 16'h1388;
    localparam logic [15:0] TMAX_RST = 16'h0980;
    localparam logic [15:0] TMIN_RST = 16'h0DCC;
    localparam logic [15:0] AMB_RST = 16'h0BA6;
    localparam logic [15:0] HEALTH_RST = 16'h0064;

    // Legal write ranges, health clamp, percent limit and temperature accumulator divisor
    localparam logic [15:0] TERM_MIN = 16'h0002;
    localparam logic [15:0] TERM_MAX = 16'h001E;
    localparam logic [15:0] VOLT_MIN = 16'h09C4;
    localparam logic [15:0] VOLT_MAX = 16'h1388;
    localparam logic [15:0] EI_OFS_MAX = 16'h03E8;
    localparam logic [15:0] TEMP_MIN = 16'h0980;
    localparam logic [15:0] TEMP_MAX = 16'h0DCC;
    localparam logic [15:0] HEALTH_MAX = 16'h0064;
    localparam logic [7:0] PERCENT_MAX = 8'h64;
    localparam logic [15:0] TEMP_ACC_DIV = 16'h0014;

    typedef enum logic [1:0] {
        GRM_WAIT = 2'b00,
        GRM_SAMPLE = 2'b01,
        GRM_DONE = 2'b10
    } grm_init_e;
endpackage : grm_pkg

// File: test/grm_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Host side of the command port: one request per call, strobe left asserted until the next call
module grm_host_model (
    input wire logic clk,
    output logic [7:0] cmd_code,
    output logic wr_stb,
    output logic [15:0] wr_data,
    output logic rd_stb
);
    // Quiet port at time zero
    initial begin
        cmd_code = 8'h02;
        wr_stb = 1'b0;
        wr_data = 16'h5AA5;
        rd_stb = 1'b0;
    end
    // Codes come only from the caller, so prohibited ones appear on command
    task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data);
        wr_stb = w;
        rd_stb = !w;
        cmd_code = code;
        wr_data = data;
        @(posedge clk);
        #1;
    endtask : xfer
    // Released lines are inverted so a stale value never looks valid
    task automatic idle();
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        cmd_code = ~cmd_code;
        wr_data = ~wr_data;
        @(posedge clk);
        #1;
    endtask : idle
endmodule : grm_host_model

// File: test/grm_register_map_bench.sv
`timescale 1ns/100ps
module grm_register_map_bench;
    import grm_pkg::*;
    logic clk, reset_n, wr_stb, rd_stb, rd_valid_r, cmd_refused_r, meas_stb, tte_stb;
    logic amb_stb, health_stb, uid_stb, seed_load_r, init_done_r;
    logic [7:0] cmd_code, relative_charge_level;
    logic [15:0] wr_data, rd_data_r, cell_voltage_mv, cell_temp_dk, tte_estimate;
    logic [15:0] ambient_temp_dk, health_pct, seed_voltage_r, lfsr_r;
    logic [31:0] uid_value;
    logic [17:0] exp_q[$];
    logic [15:0] seed_q[$];
    logic [15:0] samp [4] = '{16'h0E74, 16'h0F0A, 16'h0FA0, 16'h1036};
    logic [23:0] rst_tab [19] = '{24'h03FFFF, 24'h1C0002, 24'h1D0000, 24'h1E0000,
        24'h1F0000, 24'h200000, 24'h210000, 24'h240000, 24'h250000, 24'h260000,
        24'h270000, 24'h280000, 24'h290000, 24'h2A0000, 24'h2B1388, 24'h2C0980,
        24'h2D0DCC, 24'h300BA6, 24'h320064};
    // Code, data written, value expected on read-back
    logic [39:0] wr_tab [16] = '{40'h1C_001E_001E, 40'h1C_001F_001E, 40'h1C_0001_001E,
        40'h1D_09C3_0000, 40'h1D_1388_1388, 40'h1D_0000_0000, 40'h1E_03E9_0000,
        40'h1E_03E8_03E8, 40'h1F_1389_0000, 40'h1F_09C4_09C4, 40'h20_097F_0000,
        40'h20_0AAC_0AAC, 40'h21_0DCD_0000, 40'h21_0DCC_0DCC, 40'h03_1234_FFFF,
        40'h32_0001_0064};
    logic [7:0] bad_tab [7] = '{8'h00, 8'h01, 8'h02, 8'h22, 8'h2F, 8'h40, 8'hFF};
    int fails = 0;
    int n_checks = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Short gaps keep the start-up and minute counts inside a brief run
    grm_register_map #(.GAP_CYC(40), .MIN_CYC(400)) u_grm_register_map (
        .clk(clk), .reset_n(reset_n), .cmd_code(cmd_code), .wr_stb(wr_stb),
        .wr_data(wr_data), .rd_stb(rd_stb), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .cmd_refused_r(cmd_refused_r), .meas_stb(meas_stb), .cell_voltage_mv(cell_voltage_mv),
        .cell_temp_dk(cell_temp_dk), .relative_charge_level(relative_charge_level),
        .tte_stb(tte_stb), .tte_estimate(tte_estimate), .amb_stb(amb_stb),
        .ambient_temp_dk(ambient_temp_dk), .health_stb(health_stb), .health_pct(health_pct),
        .uid_stb(uid_stb), .uid_value(uid_value), .seed_load_r(seed_load_r),
        .seed_voltage_r(seed_voltage_r), .init_done_r(init_done_r));
    grm_host_model u_grm_host_model (.clk(clk), .cmd_code(cmd_code), .wr_stb(wr_stb),
        .wr_data(wr_data), .rd_stb(rd_stb));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and helpers
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // The note is queued before the request, so the watcher never runs ahead
    task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic ok);
        if (!ok) exp_q.push_back(18'h10000);
        u_grm_host_model.xfer(1'b1, code, data);
    endtask : wr
    task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic ok);
        exp_q.push_back(ok ? {2'b10, exp} : 18'h30000);
        u_grm_host_model.xfer(1'b0, code, 16'h0000);
    endtask : rd
    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////
    // Watcher: an answer with no note pending is compared against all ones
    always @(posedge clk) begin
        if (rd_valid_r === 1'b1 || cmd_refused_r === 1'b1) begin
            chk({rd_valid_r, cmd_refused_r, rd_data_r}, exp_q.size() ? exp_q.pop_front() : '1);
        end
        if (seed_load_r === 1'b1) begin
            chk({2'b00, seed_voltage_r}, seed_q.size() ? {2'b00, seed_q.pop_front()} : '1);
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reset_n, meas_stb, tte_stb, amb_stb, health_stb, uid_stb} = 6'h00;
        cell_voltage_mv = 16'h0E00;
        cell_temp_dk = 16'h0BA6;
        relative_charge_level = 8'h00;
        {tte_estimate, ambient_temp_dk, health_pct, uid_value} = 64'h0;
        lfsr_r = 16'hABE1;
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
        wr(CMD_SEL, SEL_KEY_BASE, 1'b0);
        u_grm_host_model.idle();
        seed_q.push_back(samp[0]);
        repeat (18) tick();
        // Each sample value is centred on its sampling edge
        for (int k = 0; k < 4; k++) begin
            cell_voltage_mv = samp[k];
            repeat (40) tick();
        end
        for (int i = 0; i < 100 && init_done_r !== 1'b1; i++) tick();
        chk({17'h0, init_done_r}, 18'h1);
        foreach (rst_tab[i]) rd(rst_tab[i][23:16], rst_tab[i][15:0], 1'b1);
        foreach (bad_tab[i]) rd(bad_tab[i], 16'h0000, 1'b0);
        wr(8'h40, 16'h0001, 1'b0);
        rd(CMD_SEL, 16'h0000, 1'b0);
        foreach (wr_tab[i]) begin
            wr(wr_tab[i][39:32], wr_tab[i][31:16], wr_tab[i][31:16] == wr_tab[i][15:0]);
            rd(wr_tab[i][39:32], wr_tab[i][15:0], 1'b1);
        end
        for (int k = 0; k < 4; k++) begin
            seed_q.push_back(samp[k]);
            wr(CMD_SEL, SEL_KEY_BASE + 16'(k), 1'b1);
            rd(CMD_RCL, 16'h0000, 1'b1);
        end
        wr(CMD_SEL, SEL_KEY_LAST + 16'h0001, 1'b0);
        wr(CMD_SEL, SEL_KEY_BASE - 16'h0001, 1'b0);
        cell_voltage_mv = 16'h0BB8;
        seed_q.push_back(samp[1]);
        wr(CMD_SEL, SEL_KEY_BASE + 16'h0001, 1'b1);
        // Every status feed lands in one cycle with the port idle
        u_grm_host_model.idle();
        cell_voltage_mv = 16'h0E10;
        cell_temp_dk = 16'h0AAC;
        relative_charge_level = 8'h32;
        {tte_estimate, ambient_temp_dk, health_pct} = 48'h0123_0AAC_0050;
        uid_value = {lfsr_next(lfsr_r), lfsr_r};
        {meas_stb, tte_stb, amb_stb, health_stb, uid_stb} = 5'h1F;
        tick();
        {meas_stb, tte_stb, amb_stb, health_stb, uid_stb} = 5'h00;
        rd(CMD_VMAX, 16'h0E10, 1'b1);
        rd(CMD_VMIN, 16'h0E10, 1'b1);
        rd(CMD_TMAX, 16'h0AAC, 1'b1);
        rd(CMD_TMIN, 16'h0AAC, 1'b1);
        rd(CMD_TTE, 16'h0123, 1'b1);
        rd(CMD_RCL, 16'h0032, 1'b1);
        rd(CMD_HEALTH, 16'h0050, 1'b1);
        rd(CMD_AMB, 16'h0AAC, 1'b1);
        rd(CMD_UID_LO, uid_value[15:0], 1'b1);
        rd(CMD_UID_HI, uid_value[31:16], 1'b1);
        // Empty cell: the estimate is pinned to zero whatever is offered
        u_grm_host_model.idle();
        relative_charge_level = 8'h00;
        tte_estimate = 16'h0456;
        health_pct = 16'h0070;
        {tte_stb, health_stb} = 2'b11;
        tick();
        {tte_stb, health_stb} = 2'b00;
        rd(CMD_TTE, 16'h0000, 1'b1);
        rd(CMD_HEALTH, HEALTH_MAX, 1'b1);
        for (int i = 0; i < 10; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wr(8'h24 + 8'(i % 6), i % 6 == 1 ? {8'h00, lfsr_r[7:0]} : lfsr_r, 1'b1);
            rd(8'h24 + 8'(i % 6), i % 6 == 1 ? {8'h00, lfsr_r[7:0]} : lfsr_r, 1'b1);
        end
        // One minute tick lands in the wait; run time carries into its upper byte
        relative_charge_level = 8'h05;
        wr(CMD_RUN_LO, 16'hFFFF, 1'b1);
        wr(CMD_RUN_HI, 16'h0012, 1'b1);
        wr(CMD_TACC_LO, 16'hFFFF, 1'b1);
        wr(CMD_TACC_HI, 16'h0001, 1'b1);
        wr(CMD_CACC_LO, 16'h0010, 1'b1);
        wr(CMD_CACC_HI, 16'h0000, 1'b1);
        u_grm_host_model.idle();
        repeat (120) tick();
        rd(CMD_RUN_LO, 16'h0000, 1'b1);
        rd(CMD_RUN_HI, 16'h0013, 1'b1);
        // 0x0AAC tenths of a kelvin over 20 rounds down to 0x88
        rd(CMD_TACC_LO, 16'h0087, 1'b1);
        rd(CMD_TACC_HI, 16'h0002, 1'b1);
        rd(CMD_CACC_LO, 16'h0015, 1'b1);
        rd(CMD_CACC_HI, 16'h0000, 1'b1);
        u_grm_host_model.idle();
        repeat (3) tick();
        chk(18'(exp_q.size() + seed_q.size()), 18'h0);
        close_out();
    end
endmodule : grm_register_map_bench
